// file: core/init_cfg_pkg.sv
// Package: constants, field layouts and types for the initialization registers
//
// Rules for the initialization registers
// (RL1) Writes to either initialization register take effect only while the device is in its initialization phase.
// (RL2) Regulator bit 7 chooses whether the second wake input is sampled any time or only during the first wake input activation.
// (RL3) Regulator bits 6:5 pick the supply under-voltage response: reset near 0.9, interrupt 0.9 plus reset 0.7, or reset 0.7.
// (RL4) Regulator bits 4:3 pick the reset low time after supply recovery: 1, 5, 10 or 20 ms.
// (RL5) Regulator bit 2 picks the auxiliary regulator voltage, 0 for 3.3 V and 1 for 5.0 V.
// (RL6) Regulator bits 1:0 pick the first wake input activation time: 200, 400, 800 or 1600 us.
// (RL7) The watchdog register holds deadline enable, monitor select, timer select, safe option, two-bit operation, window select and cranking; monitor and window reset to 1.
// (RL8) The host sends a 16-bit word: address and check bit in the first byte, data MSB first in the second.
// (RL9) With the deadline bit set the host must read the interrupt source within the current watchdog period plus two.
// (RL10) The safe option bit drives the safe output low at the first reset pulse when 0, at the second consecutive one when 1.
// (RL11) A write outside the initialization phase is ignored and the register keeps its value.
package init_cfg_pkg;

   // ****************************************************************
   // Register map and reset values
   // ****************************************************************
   localparam logic [4:0] REGULATOR_INIT_ADDR = 5'h05;
   localparam logic [4:0] WATCHDOG_INIT_ADDR  = 5'h06;
   localparam logic [7:0] REGULATOR_INIT_RST  = 8'h80;
   localparam logic [7:0] WATCHDOG_INIT_RST   = 8'h42;

   // ****************************************************************
   // Serial word layout
   // ****************************************************************
   localparam int WORD_BITS   = 16;
   localparam int ADDR_MSB    = 13;
   localparam int ADDR_LSB    = 9;
   localparam int CHECK_BIT   = 8;
   localparam int MODE_MSB    = 15;
   localparam int MODE_LSB    = 14;
   localparam logic [1:0] MODE_WRITE = 2'h1;

   typedef struct packed {
      logic       io_sync_during_act;   // bit 7
      logic [1:0] supply_uv_threshold_sel;
      logic [1:0] reset_pulse_len_sel;
      logic       aux_voltage_sel;
      logic [1:0] cyclic_act_time_sel;
   } regulator_init_s;

   typedef struct packed {
      logic       irq_read_deadline_en;
      logic       lp_current_monitor_sel;
      logic       lp_current_timer_sel;
      logic       safe_on_second_reset;
      logic [1:0] watchdog_operation_sel;
      logic       watchdog_window_sel;
      logic       cranking_sel;
   } watchdog_init_s;

   typedef enum logic [1:0] {UV_RST_HI, UV_INT_HI_RST_LO, UV_RST_LO} uv_mode_e;

   // ****************************************************************
   // Timing, in cycles of the 100 MHz clock
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int RST_LEN_1_MS  = 1;
   localparam int RST_LEN_5_MS  = 5;
   localparam int RST_LEN_10_MS = 10;
   localparam int RST_LEN_20_MS = 20;
   localparam int CYC_ACT_200_US = 200;
   localparam int MS_CYCLES = 1000000 / CLK_PERIOD_NS;
   localparam int US_CYCLES = 1000 / CLK_PERIOD_NS;
   localparam logic [23:0] RST_LEN_CYC_1  = 24'(RST_LEN_1_MS * MS_CYCLES);
   localparam logic [23:0] RST_LEN_CYC_5  = 24'(RST_LEN_5_MS * MS_CYCLES);
   localparam logic [23:0] RST_LEN_CYC_10 = 24'(RST_LEN_10_MS * MS_CYCLES);
   localparam logic [23:0] RST_LEN_CYC_20 = 24'(RST_LEN_20_MS * MS_CYCLES);
   localparam logic [23:0] CYC_ACT_CYC_200 = 24'(CYC_ACT_200_US * US_CYCLES);

endpackage

// file: core/init_config_registers.sv
// Initialization configuration register bank with 16-bit serial write port
`timescale 1ns/10ps
`default_nettype none
module init_config_registers (
   input  wire logic                            clock_i,        // 100 MHz clock
   input  wire logic                            rstn_i,         // Power-on reset, active low
   input  wire logic                            init_phase_i,   // High while in init phase
   input  wire logic                            word_valid_i,   // One-cycle strobe, word ready
   input  wire logic [15:0]                     word_i,         // Received serial word
   output logic                                 write_done_o,   // Pulse: write accepted
   output logic                                 write_refused_o,// Pulse: write ignored
   output init_cfg_pkg::regulator_init_s        regulator_o,    // Regulator init contents
   output init_cfg_pkg::watchdog_init_s         watchdog_o,     // Watchdog init contents
   output init_cfg_pkg::uv_mode_e               uv_mode_o,      // Decoded under-voltage mode
   output logic [23:0]                          reset_len_cyc_o,// Reset low time in cycles
   output logic [23:0]                          cyclic_act_cyc_o // First wake act time, cycles
);
   import init_cfg_pkg::*;

   logic [4:0] addr;
   logic       is_write;
   logic       hit_reg;
   logic       hit_wd;
   logic       parity_ok;
   logic [7:0] data_byte;
   logic       any_hit;
   logic       reg_write_en;
   logic       wd_write_en;
   logic       any_write;
   logic       sync_bit_in;
   logic       aux_bit_in;
   logic       safe_bit_in;

   // ****************************************************************
   // Command decode
   // ****************************************************************
   // Check bit makes the word odd parity; a bad word is never stored
   assign addr      = word_i[ADDR_MSB:ADDR_LSB];
   assign is_write  = word_i[MODE_MSB:MODE_LSB] == MODE_WRITE;
   assign parity_ok = ^word_i;
   assign hit_reg   = word_valid_i && is_write && parity_ok && addr == REGULATOR_INIT_ADDR;
   assign hit_wd    = word_valid_i && is_write && parity_ok && addr == WATCHDOG_INIT_ADDR;

   // Init phase gates every store; outside it a hit only raises the refusal
   assign any_hit      = hit_reg || hit_wd;
   assign reg_write_en = hit_reg && init_phase_i; // RL1
   assign wd_write_en  = hit_wd && init_phase_i;  // RL1
   assign any_write    = reg_write_en || wd_write_en;

   // Single-bit taps of the data byte, read only by the write path checks below
   assign data_byte   = word_i[7:0];
   assign sync_bit_in = data_byte[7]; // RL2
   assign aux_bit_in  = data_byte[2]; // RL5
   assign safe_bit_in = data_byte[4]; // RL10

   // ****************************************************************
   // Register storage
   // ****************************************************************
   // Data byte is the low half, MSB first on the wire
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         regulator_o <= regulator_init_s'(REGULATOR_INIT_RST); // RL7
      end else if (hit_reg && init_phase_i) begin // RL1 RL11
         regulator_o <= regulator_init_s'(word_i[7:0]); // RL8
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         watchdog_o <= watchdog_init_s'(WATCHDOG_INIT_RST); // RL7
      end else if (hit_wd && init_phase_i) begin // RL1 RL11
         watchdog_o <= watchdog_init_s'(word_i[7:0]); // RL10
      end
   end

   // Status pulses for the host-facing side
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         write_done_o    <= 1'b0;
         write_refused_o <= 1'b0;
      end else begin
         write_done_o    <= (hit_reg || hit_wd) && init_phase_i;
         write_refused_o <= (hit_reg || hit_wd) && !init_phase_i; // RL11
      end
   end

   // ****************************************************************
   // Field decode for the analog and timing blocks
   // ****************************************************************
   // Codes 00 and 11 give the same response
   always_comb begin
      unique case (regulator_o.supply_uv_threshold_sel) // RL3
         2'b01:   uv_mode_o = UV_INT_HI_RST_LO;
         2'b10:   uv_mode_o = UV_RST_LO;
         default: uv_mode_o = UV_RST_HI;
      endcase
   end

   always_comb begin
      unique case (regulator_o.reset_pulse_len_sel) // RL4
         2'b00: reset_len_cyc_o = RST_LEN_CYC_1;
         2'b01: reset_len_cyc_o = RST_LEN_CYC_5;
         2'b10: reset_len_cyc_o = RST_LEN_CYC_10;
         2'b11: reset_len_cyc_o = RST_LEN_CYC_20;
      endcase
   end

   // Doubling per code step; aux voltage and sync bit pass straight out
   assign cyclic_act_cyc_o = CYC_ACT_CYC_200 << regulator_o.cyclic_act_time_sel; // RL6 RL2 RL5

   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_locked_outside_init: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL1
      !init_phase_i |=> $stable(regulator_o) && $stable(watchdog_o))
      else $error("init register changed outside init phase");
   a_reg_write_lands: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL8
      hit_reg && init_phase_i |=> regulator_o == regulator_init_s'($past(data_byte)))
      else $error("regulator write not stored");
   a_wd_write_lands: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL7
      hit_wd && init_phase_i |=> watchdog_o == watchdog_init_s'($past(data_byte)))
      else $error("watchdog write not stored");
   a_refused_pulse: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL11
      (hit_reg || hit_wd) && !init_phase_i |=> write_refused_o && !write_done_o)
      else $error("refused write not flagged");
   a_uv_equal_codes: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL3
      regulator_o.supply_uv_threshold_sel[1] == regulator_o.supply_uv_threshold_sel[0]
      |-> uv_mode_o == UV_RST_HI)
      else $error("uv codes 00 and 11 differ");
   a_reset_len_max: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL4
      regulator_o.reset_pulse_len_sel == 2'b11 |-> reset_len_cyc_o == 24'h1E_8480)
      else $error("20 ms reset length wrong");
   a_cyclic_max: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL6
      regulator_o.cyclic_act_time_sel == 2'b11 |-> cyclic_act_cyc_o == 24'h02_7100)
      else $error("1600 us activation wrong");
   a_bad_parity_drop: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL8
      word_valid_i && !parity_ok |=> !write_done_o && !write_refused_o)
      else $error("bad parity word acted on");

   // ****************************************************************
   // Write path checks
   // ****************************************************************
   // A byte only moves on an accepted write or on reset
   a_reset_defaults: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL7
      $rose(rstn_i) |-> regulator_o == regulator_init_s'(REGULATOR_INIT_RST)
      && watchdog_o == watchdog_init_s'(WATCHDOG_INIT_RST))
      else $error("init register not at default after reset");
   a_done_on_write: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL1
      any_write |=> write_done_o && !write_refused_o)
      else $error("accepted write not flagged");
   a_done_needs_write: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL1
      write_done_o |-> $past(any_write))
      else $error("done pulse without a write");
   a_refused_needs_hit: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL11
      write_refused_o |-> $past(any_hit) && !$past(init_phase_i))
      else $error("refusal pulse without a refused write");
   a_pulses_exclusive: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL11
      !(write_done_o && write_refused_o))
      else $error("done and refused pulses together");
   a_idle_no_pulse: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL11
      !any_hit |=> !write_done_o && !write_refused_o)
      else $error("pulse without an init register hit");
   a_mode_gate: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL8
      word_valid_i && !is_write |=> !write_done_o && !write_refused_o)
      else $error("non-write word acted on");
   a_addr_gate: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL8
      word_valid_i && addr != REGULATOR_INIT_ADDR && addr != WATCHDOG_INIT_ADDR
      |=> !write_done_o && !write_refused_o)
      else $error("word for another address acted on");
   // Holds cover the refused case too: a refused hit leaves both bytes alone
   a_reg_holds: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL11
      !reg_write_en |=> $stable(regulator_o))
      else $error("regulator register changed without a write");
   a_wd_holds: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL11
      !wd_write_en |=> $stable(watchdog_o))
      else $error("watchdog register changed without a write");
   a_sync_bit_lands: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL2
      reg_write_en |=> regulator_o.io_sync_during_act == $past(sync_bit_in))
      else $error("sync select bit misplaced");
   a_aux_bit_lands: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL5
      reg_write_en |=> regulator_o.aux_voltage_sel == $past(aux_bit_in))
      else $error("aux voltage bit misplaced");
   a_safe_bit_lands: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL10
      wd_write_en |=> watchdog_o.safe_on_second_reset == $past(safe_bit_in))
      else $error("safe option bit misplaced");

   // ****************************************************************
   // Field decode checks
   // ****************************************************************
   // Expected counts written out per code, not taken from the decode tables
   a_uv_int_code: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL3
      regulator_o.supply_uv_threshold_sel == 2'b01 |-> uv_mode_o == UV_INT_HI_RST_LO)
      else $error("uv code 01 not interrupt plus low reset");
   a_uv_low_code: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL3
      regulator_o.supply_uv_threshold_sel == 2'b10 |-> uv_mode_o == UV_RST_LO)
      else $error("uv code 10 not low reset");
   a_reset_len_codes: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL4
      reset_len_cyc_o == (regulator_o.reset_pulse_len_sel == 2'b00 ? 24'h01_86A0 :
                          regulator_o.reset_pulse_len_sel == 2'b01 ? 24'h07_A120 :
                          regulator_o.reset_pulse_len_sel == 2'b10 ? 24'h0F_4240 :
                                                                     24'h1E_8480))
      else $error("reset length code decoded wrong");
   a_cyclic_codes: assert property (@(posedge clock_i) disable iff (!rstn_i) // RL6
      cyclic_act_cyc_o == (regulator_o.cyclic_act_time_sel == 2'b00 ? 24'h00_4E20 :
                           regulator_o.cyclic_act_time_sel == 2'b01 ? 24'h00_9C40 :
                           regulator_o.cyclic_act_time_sel == 2'b10 ? 24'h01_3880 :
                                                                      24'h02_7100))
      else $error("activation time code decoded wrong");

   // ****************************************************************
   // Cover points
   // ****************************************************************
   // Main scenarios: both stores, a refusal, a spoiled word, the interrupt mode
   c_reg_write: cover property (@(posedge clock_i) disable iff (!rstn_i) hit_reg && init_phase_i);
   c_wd_write: cover property (@(posedge clock_i) disable iff (!rstn_i) hit_wd && init_phase_i);
   c_refused: cover property (@(posedge clock_i) disable iff (!rstn_i) write_refused_o);
   c_bad_parity: cover property (@(posedge clock_i) disable iff (!rstn_i)
      word_valid_i && !parity_ok);
   c_uv_interrupt: cover property (@(posedge clock_i) disable iff (!rstn_i)
      uv_mode_o == UV_INT_HI_RST_LO);

endmodule
`default_nettype wire

// file: test/host_word_model.sv
// Host model: frames 16-bit serial words and strobes them into the bank
`timescale 1ns/10ps
`default_nettype none
module host_word_model (
   input  wire logic        clock_i,      // Bench clock
   output logic             word_valid_o, // One-cycle word strobe
   output logic [15:0]      word_o        // Framed serial word
);
   initial begin
      word_valid_o = 1'b0;
      word_o       = 16'h0000;
   end
   // Mode, address, check bit, data MSB first; bad_chk spoils the check bit
   task automatic send(input logic [1:0] mode, input logic [4:0] addr,
                       input logic [7:0] data, input logic bad_chk);
      logic [15:0] w;
      w = {mode, addr, 1'b0, data};
      w[8] = ~(^w) ^ bad_chk;
      @(negedge clock_i);
      word_o       <= w;
      word_valid_o <= 1'b1;
      @(negedge clock_i);
      word_valid_o <= 1'b0;
      word_o       <= ~w; // Released word never shows the stale value
   endtask
endmodule
`default_nettype wire

// file: test/init_config_registers_tb_top.sv
// Self-checking bench for the initialization register bank
`timescale 1ns/10ps
`default_nettype none
module init_config_registers_tb_top;
   import init_cfg_pkg::*;
   logic            clock = 1'b0;
   logic            rstn = 1'b0;
   logic            init_phase = 1'b1;
   logic            word_valid, write_done, write_refused;
   logic [15:0]     word;
   regulator_init_s regulator;
   watchdog_init_s  watchdog;
   uv_mode_e        uv_mode;
   logic [23:0]     reset_len_cyc, cyclic_act_cyc;
   int              err_total = 0;
   int              check_count = 0;
   always #5 clock = ~clock;
   host_word_model i_host_word_model (.clock_i(clock), .word_valid_o(word_valid), .word_o(word));
   init_config_registers i_init_config_registers (.clock_i(clock), .rstn_i(rstn),
      .init_phase_i(init_phase), .word_valid_i(word_valid), .word_i(word),
      .write_done_o(write_done), .write_refused_o(write_refused), .regulator_o(regulator),
      .watchdog_o(watchdog), .uv_mode_o(uv_mode), .reset_len_cyc_o(reset_len_cyc),
      .cyclic_act_cyc_o(cyclic_act_cyc));
   // ****************************************************************
   // Compare and close
   // ****************************************************************
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic test_reset();
      check("regulator", 24'(regulator), 24'h80);
      check("watchdog", 24'(watchdog), 24'h42);
      check("uv mode", 24'(uv_mode), 24'(UV_RST_HI));
      $display("test reset done");
   endtask
   // Every code of every regulator field, back to back, then the watchdog byte
   task automatic test_fields();
      uv_mode_e    uv_exp [4] = '{UV_RST_HI, UV_INT_HI_RST_LO, UV_RST_LO, UV_RST_HI};
      logic [23:0] len_exp [4] = '{24'd100000, 24'd500000, 24'd1000000, 24'd2000000};
      logic [7:0]  d;
      for (int i = 0; i < 4; i++) begin
         d = {i[0], i[1:0], i[1:0], i[0], i[1:0]};
         i_host_word_model.send(2'h1, 5'h05, d, 1'b0);
         check("done", 24'(write_done), 24'h1);
         check("regulator", 24'(regulator), 24'(d));
         check("uv mode", 24'(uv_mode), 24'(uv_exp[i]));
         check("reset len", reset_len_cyc, len_exp[i]);
         check("aux sel", 24'(regulator.aux_voltage_sel), 24'(i[0]));
         check("act time", cyclic_act_cyc, 24'd20000 << i);
      end
      i_host_word_model.send(2'h1, 5'h06, 8'hB5, 1'b0);
      check("watchdog", 24'(watchdog), 24'hB5);
      check("safe opt", 24'(watchdog.safe_on_second_reset), 24'h1);
      check("deadline en", 24'(watchdog.irq_read_deadline_en), 24'h1);
      @(negedge clock);
      check("done gone", 24'(write_done), 24'h0);
      $display("test fields done");
   endtask
   // Writes outside init are refused, a spoiled check bit is ignored
   task automatic test_refused();
      @(negedge clock) init_phase <= 1'b0;
      i_host_word_model.send(2'h1, 5'h05, 8'h3C, 1'b0);
      check("refused", 24'(write_refused), 24'h1);
      check("regulator", 24'(regulator), 24'hFF);
      i_host_word_model.send(2'h1, 5'h06, 8'h00, 1'b0);
      check("watchdog", 24'(watchdog), 24'hB5);
      @(negedge clock) init_phase <= 1'b1;
      i_host_word_model.send(2'h1, 5'h05, 8'h3C, 1'b1);
      check("done", 24'(write_done), 24'h0);
      check("regulator", 24'(regulator), 24'hFF);
      i_host_word_model.send(2'h2, 5'h05, 8'h11, 1'b0);
      check("other mode", 24'(regulator), 24'hFF);
      i_host_word_model.send(2'h1, 5'h07, 8'h22, 1'b0);
      check("other addr", 24'(write_done), 24'h0);
      check("other addr refused", 24'(write_refused), 24'h0);
      $display("test refused done");
   endtask
   // Hang guard
   initial begin
      repeat (2000) @(posedge clock);
      err_total++;
      stop_test();
   end
   // Main sequence, with a second reset and reset check at the end
   initial begin
      repeat (3) @(posedge clock);
      @(negedge clock) rstn <= 1'b1;
      test_reset();
      test_fields();
      test_refused();
      @(negedge clock) rstn <= 1'b0;
      @(negedge clock) rstn <= 1'b1;
      test_reset();
      stop_test();
   end
endmodule
`default_nettype wire
